// File: logic/hdgpio_pkg.sv
// Package: register map, field positions and reset values for the host data pin GPIO block
package hdgpio_pkg;
   localparam logic [15:0] HDGPIO_CTRL_ADDR = 16'h003c;
   localparam logic [15:0] HDGPIO_STAT_ADDR = 16'h003d;
   localparam int HDGPIO_ROUTE_BIT = 15;
   localparam logic [15:0] HDGPIO_CTRL_RESET = 16'h0000;
   localparam logic [7:0] HDGPIO_LEVEL_RESET = 8'h00;
endpackage

// File: logic/hdgpio_top.sv
// Host data pin general-purpose I/O: control and status registers and pin drivers
`timescale 1ns/100ps
module hdgpio_top #(
   parameter bit TWO_TIMERS = 1'b1
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic host_port_enable_pin,
   input wire logic [15:0] mmr_addr,
   input wire logic mmr_wr,
   input wire logic [15:0] mmr_wdata,
   output logic [15:0] mmr_rdata,
   input wire logic second_timer_out,
   input wire logic [7:0] host_data_pin_in,
   output logic [7:0] host_data_pin_out,
   output logic [7:0] host_data_pin_oe,
   output logic host_interrupt_pin_gpio_out,
   output logic host_interrupt_pin_gpio_oe,
   output logic host_port_active
);
   // One-hot states of the strap capture sequencer
   typedef enum logic [1:0] {
      HDGPIO_STRAP_CAPTURE = 2'b01,
      HDGPIO_STRAP_RUN = 2'b10
   } hdgpio_strap_t;

   // Strap sequencer and host port mode
   hdgpio_strap_t strap_state;
   hdgpio_strap_t next_strap_state;
   logic strap_pending;
   logic host_port_on;
   logic next_host_port_on;
   logic regs_locked;

   // Control register route field and its next value
   logic second_timer_route_enable;
   logic next_route_enable;
   logic route_allowed;

   // Per-pin state gathered from the pin slices
   wire logic [7:0] pin_direction_bit;
   wire logic [7:0] pin_level_bit;
   wire logic [7:0] sensed;
   wire logic [7:0] status_bits;

   // Register bus decode and read path
   logic sel_ctrl;
   logic sel_stat;
   logic wr_ctrl;
   logic wr_stat;
   logic [15:0] ctrl_image;
   logic [15:0] stat_image;
   logic [15:0] next_rdata;

   // Next values of the registered pin-side outputs
   logic [7:0] next_pin_out;
   logic [7:0] next_pin_oe;
   logic next_irq_out;
   logic next_irq_oe;
   logic next_port_active;

   // Address decode; only the two mapped words respond
   assign sel_ctrl = (mmr_addr == hdgpio_pkg::HDGPIO_CTRL_ADDR);
   assign sel_stat = (mmr_addr == hdgpio_pkg::HDGPIO_STAT_ADDR);
   assign wr_ctrl = mmr_wr && sel_ctrl;
   assign wr_stat = mmr_wr && sel_stat;

   // Strap sequencer: sample the enable pin once, then stay put until reset
   always_comb begin
      next_strap_state = strap_state;
      case (strap_state)
         HDGPIO_STRAP_CAPTURE: begin
            next_strap_state = HDGPIO_STRAP_RUN;
         end
         HDGPIO_STRAP_RUN: begin
            next_strap_state = HDGPIO_STRAP_RUN;
         end
         default: begin
            next_strap_state = HDGPIO_STRAP_CAPTURE;
         end
      endcase
   end

   // Sequencer state register; reset parks it in the capture state
   always_ff @(posedge core_clk) begin
      if (reset) begin
         strap_state <= HDGPIO_STRAP_CAPTURE;
      end else begin
         strap_state <= next_strap_state;
      end
   end

   // The first edge after reset is the capture edge
   assign strap_pending = (strap_state == HDGPIO_STRAP_CAPTURE);

   // Host port mode follows the strap only on the capture edge
   always_comb begin
      next_host_port_on = host_port_on;
      if (strap_pending) begin
         next_host_port_on = host_port_enable_pin;
      end
   end

   // Host port counts as on during reset, so the pins start undriven
   always_ff @(posedge core_clk) begin
      if (reset) begin
         host_port_on <= 1'b1;
      end else begin
         host_port_on <= next_host_port_on;
      end
   end

   // Control writes are refused until the strap is known and while the port is on
   assign regs_locked = host_port_on || strap_pending;

   // Route bit exists only when a second timer is fitted
   assign route_allowed = TWO_TIMERS;

   // Next route bit: forced clear while locked, loaded by control writes
   always_comb begin
      next_route_enable = second_timer_route_enable;
      if (regs_locked) begin
         next_route_enable = 1'b0;
      end else if (wr_ctrl) begin
         next_route_enable = route_allowed
            && mmr_wdata[hdgpio_pkg::HDGPIO_ROUTE_BIT];
      end
   end

   // Route bit register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         second_timer_route_enable <=
            hdgpio_pkg::HDGPIO_CTRL_RESET[hdgpio_pkg::HDGPIO_ROUTE_BIT];
      end else begin
         second_timer_route_enable <= next_route_enable;
      end
   end

   // Per-pin slices: direction, output level and input synchroniser
   for (genvar g = 0; g < 8; g++) begin : g_pin
      logic dir_q;
      logic next_dir;
      logic level_q;
      logic next_level;
      logic meta_q;
      logic mid_q;
      logic late_q;
      logic sensed_q;
      logic next_sensed;

      // Next direction: forced to input while locked, else loaded by writes
      always_comb begin
         next_dir = dir_q;
         if (regs_locked) begin
            next_dir = 1'b0;
         end else if (wr_ctrl) begin
            next_dir = mmr_wdata[g];
         end
      end

      // Direction flop; every pin starts as an input
      always_ff @(posedge core_clk) begin
         if (reset) begin
            dir_q <= hdgpio_pkg::HDGPIO_CTRL_RESET[g];
         end else begin
            dir_q <= next_dir;
         end
      end

      // Next level: status writes land only on output pins
      always_comb begin
         next_level = level_q;
         if (wr_stat && dir_q) begin
            next_level = mmr_wdata[g];
         end
      end

      // Output level flop
      always_ff @(posedge core_clk) begin
         if (reset) begin
            level_q <= hdgpio_pkg::HDGPIO_LEVEL_RESET[g];
         end else begin
            level_q <= next_level;
         end
      end

      // Three flops on the pin; the first is read by the second only
      always_ff @(posedge core_clk) begin
         if (reset) begin
            meta_q <= 1'b0;
            mid_q <= 1'b0;
            late_q <= 1'b0;
         end else begin
            meta_q <= host_data_pin_in[g];
            mid_q <= meta_q;
            late_q <= mid_q;
         end
      end

      // A new level counts once the second and third stages agree
      always_comb begin
         next_sensed = sensed_q;
         if (mid_q == late_q) begin
            next_sensed = late_q;
         end
      end

      // Sensed level flop
      always_ff @(posedge core_clk) begin
         if (reset) begin
            sensed_q <= 1'b0;
         end else begin
            sensed_q <= next_sensed;
         end
      end

      // Slice results onto the shared vectors
      assign pin_direction_bit[g] = dir_q;
      assign pin_level_bit[g] = level_q;
      assign sensed[g] = sensed_q;
      assign status_bits[g] = dir_q ? level_q : sensed_q;
   end

   // Control word image; reserved bits 14 to 8 always read zero
   always_comb begin
      ctrl_image = 16'h0000;
      ctrl_image[hdgpio_pkg::HDGPIO_ROUTE_BIT] = second_timer_route_enable;
      ctrl_image[7:0] = pin_direction_bit;
   end

   // Status word image; upper byte reserved
   always_comb begin
      stat_image = 16'h0000;
      stat_image[7:0] = status_bits;
   end

   // Read select; unmapped addresses read zero
   always_comb begin
      next_rdata = 16'h0000;
      if (sel_ctrl) begin
         next_rdata = ctrl_image;
      end else if (sel_stat) begin
         next_rdata = stat_image;
      end
   end

   // Pin-side next values
   always_comb begin
      next_pin_out = pin_level_bit;
      next_pin_oe = pin_direction_bit;
      next_irq_out = second_timer_out;
      next_irq_oe = second_timer_route_enable && !host_port_on;
      next_port_active = host_port_on;
   end

   // Registered read data, valid one edge after the address
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mmr_rdata <= 16'h0000;
      end else begin
         mmr_rdata <= next_rdata;
      end
   end

   // Registered drive levels of the data pins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         host_data_pin_out <= 8'h00;
      end else begin
         host_data_pin_out <= next_pin_out;
      end
   end

   // Registered output enables of the data pins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         host_data_pin_oe <= 8'h00;
      end else begin
         host_data_pin_oe <= next_pin_oe;
      end
   end

   // Registered timer level for the interrupt pin
   always_ff @(posedge core_clk) begin
      if (reset) begin
         host_interrupt_pin_gpio_out <= 1'b0;
      end else begin
         host_interrupt_pin_gpio_out <= next_irq_out;
      end
   end

   // Registered interrupt pin enable; never on while the host port owns it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         host_interrupt_pin_gpio_oe <= 1'b0;
      end else begin
         host_interrupt_pin_gpio_oe <= next_irq_oe;
      end
   end

   // Registered host port mode, seen as on throughout reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         host_port_active <= 1'b1;
      end else begin
         host_port_active <= next_port_active;
      end
   end
endmodule

// File: test/hdgpio_board.sv
// Board model on the eight host data pins
`timescale 1ns/100ps
module hdgpio_board(
   input wire logic [7:0] host_data_pin_oe,
   input wire logic [7:0] host_data_pin_out,
   input wire logic [7:0] ext,
   output logic [7:0] host_data_pin_in
);
   // Driven pins carry the block's level, free pins the board's level
   assign host_data_pin_in = host_data_pin_oe & host_data_pin_out | ~host_data_pin_oe & ext;
endmodule

// File: test/hdgpio_assertions.sv
// Port assertions for the host data pin GPIO block
`timescale 1ns/100ps
module hdgpio_chk(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic host_port_active,
   input wire logic mmr_wr,
   input wire logic second_timer_out,
   input wire logic host_interrupt_pin_gpio_out,
   input wire logic host_interrupt_pin_gpio_oe,
   input wire logic [15:0] mmr_addr,
   input wire logic [15:0] mmr_wdata,
   input wire logic [15:0] mmr_rdata,
   input wire logic [7:0] host_data_pin_out,
   input wire logic [7:0] host_data_pin_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // Short names and accepted control writes
   wire on = host_port_active;
   wire [7:0] oe = host_data_pin_oe;
   wire [15:0] a = mmr_addr;
   wire [15:0] wd = mmr_wdata;
   wire cw = mmr_wr && a == 16'h003c && !on;
   chk_pin_idle: assert property (on |-> !oe) else $error("pin driven");
   chk_irq_idle: assert property (on |-> !host_interrupt_pin_gpio_oe) else $error("irq");
   chk_dir_write: assert property (cw |-> ##2 oe == $past(wd[7:0], 2)) else $error("dir");
   chk_pin_level: assert property (mmr_wr && a == 16'h003d |-> ##2
      !((host_data_pin_out ^ $past(wd[7:0], 2)) & oe & $past(oe))) else $error("level");
   chk_irq_level: assert property (host_interrupt_pin_gpio_oe |->
      host_interrupt_pin_gpio_out == $past(second_timer_out)) else $error("irq level");
   chk_ctrl_rsvd: assert property ($past(a) == 16'h003c |-> !mmr_rdata[14:8])
      else $error("ctrl rsvd");
   chk_stat_rsvd: assert property ($past(a) == 16'h003d |-> !mmr_rdata[15:8])
      else $error("stat rsvd");
   chk_ctrl_zero: assert property (on && $past(a) == 16'h003c |-> !mmr_rdata)
      else $error("ctrl");
   // Main traffic seen
   cover property (cw);
   cover property (host_interrupt_pin_gpio_oe);
   cover property (on && mmr_wr);
endmodule
bind hdgpio_top hdgpio_chk u_chk(.*);

// File: test/testbench.sv
// Self-checking testbench for the host data pin GPIO block
`timescale 1ns/100ps
module testbench;
   logic core_clk = 0, reset = 1, host_port_enable_pin = 1, mmr_wr = 0, second_timer_out = 0;
   logic host_interrupt_pin_gpio_out, host_interrupt_pin_gpio_oe, host_port_active;
   logic [15:0] mmr_addr = 0, mmr_wdata = 0, mmr_rdata, w;
   logic [7:0] ext = 0, host_data_pin_in, host_data_pin_out, host_data_pin_oe, d;
   logic [15:0] r1;
   logic irq1;
   int err_count = 0, samples_checked = 0;
   // Block with the board on its pins, plus a single-timer variant
   hdgpio_top DUT(.*);
   hdgpio_board board(.*);
   hdgpio_top #(.TWO_TIMERS(1'b0)) dut_one_timer(
      .core_clk(core_clk),
      .reset(reset),
      .host_port_enable_pin(host_port_enable_pin),
      .mmr_addr(mmr_addr),
      .mmr_wr(mmr_wr),
      .mmr_wdata(mmr_wdata),
      .mmr_rdata(r1),
      .second_timer_out(second_timer_out),
      .host_data_pin_in(ext),
      .host_data_pin_out(),
      .host_data_pin_oe(),
      .host_interrupt_pin_gpio_out(),
      .host_interrupt_pin_gpio_oe(irq1),
      .host_port_active()
   );
   // Expected status word: written level on outputs, board level on inputs
   function automatic logic [15:0] exp_status(input logic [7:0] lvl, dir, pin);
      return {8'h00, (lvl & dir) | (pin & ~dir)};
   endfunction
   // Clock, random timer level, watchdog
   initial forever #25 core_clk = ~core_clk;
   always @(posedge core_clk) second_timer_out <= 1'($urandom);
   initial begin
      #100us;
      err_count++;
      results;
   end
   task chk(input logic [15:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %h %h", $time, got, exp);
      end
   endtask
   // Write a register, then read it back
   task acc(input logic [15:0] a, v, e);
      @(posedge core_clk) {mmr_addr, mmr_wdata, mmr_wr} <= {a, v, 1'b1};
      @(posedge core_clk) mmr_wr <= 0;
      @(posedge core_clk) #1 chk(mmr_rdata, e);
   endtask
   task results;
      if (err_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Host port on, then off; all-ones corner first, then random
   initial begin
      void'($urandom(95));
      for (int h = 1; h >= 0; h--) begin
         @(posedge core_clk) {reset, host_port_enable_pin} <= {1'b1, 1'(h)};
         repeat (6) @(posedge core_clk);
         reset <= 0;
         repeat (2) @(posedge core_clk);
         for (int i = 0; i < 16; i++) begin
            w = i ? 16'($urandom) : 16'hffff;
            d = h ? 8'h00 : w[7:0];
            @(posedge core_clk) ext <= 8'($urandom);
            acc(16'h003c, w, h ? 16'h0000 : w & 16'h80ff);
            chk(r1, h ? 16'h0000 : w & 16'h00ff);
            chk(16'(irq1), 16'h0000);
            repeat (4) @(posedge core_clk);
            acc(16'h003d, ~w, exp_status(~w[7:0], d, ext));
            chk(16'(host_data_pin_oe), 16'(d));
            chk(16'(host_data_pin_out & d), 16'(~w[7:0] & d));
            chk(16'(host_port_active), 16'(h));
            chk(16'(host_interrupt_pin_gpio_oe), 16'(w[15] & !h));
         end
      end
      acc(16'h0040, 16'hffff, 16'h0000);
      results;
   end
endmodule
